// *** rtl/rx_threshold_demod_config.sv ***
// Operation
// - decoder input below the four-bit minimum level is not evaluated.
// - threshold bit 3 is reserved with no function.
// - collision flagged only when weaker half-bit reaches level relative to stronger.
// - threshold register at index 18h, reset value 84h.
// - channel field: 00 stronger, 01 stronger and held, 10 combine, 11 reserved.
// - channel field selection applies only while fixed-channel bit is clear.
// - fixed channel set: low bit 0 receives on I, 1 on Q.
// - secure-element serial mode forces fixed channel and reuses channel field.
// - even bit clear: timer divides carrier by twice prescaler plus one.
// - even bit set: timer divides carrier by twice prescaler plus two.
// - receive time constant sets PLL in reception; 00 freezes the PLL.
// - burst time constant in lowest bits sets PLL whenever not receiving.
// - demodulator register at index 19h, reset value 4Dh.
//
// The AXI4-Lite interface to the registers was chosen for this implementation.
`timescale 1ns/10ps
module rx_threshold_demod_config
  import rx_cfg_pkg::*;
(
  input  wire logic               sys_clk,
  input  wire logic               rstn,
  // axi4-lite write address
  input  wire logic [ADDR_W-1:0]  s_axi_awaddr,
  input  wire logic               s_axi_awvalid,
  output logic                    s_axi_awready,
  // axi4-lite write data
  input  wire logic [DATA_W-1:0]  s_axi_wdata,
  input  wire logic [3:0]         s_axi_wstrb,
  input  wire logic               s_axi_wvalid,
  output logic                    s_axi_wready,
  // axi4-lite write response
  output logic [1:0]              s_axi_bresp,
  output logic                    s_axi_bvalid,
  input  wire logic               s_axi_bready,
  // axi4-lite read address
  input  wire logic [ADDR_W-1:0]  s_axi_araddr,
  input  wire logic               s_axi_arvalid,
  output logic                    s_axi_arready,
  // axi4-lite read data
  output logic [DATA_W-1:0]       s_axi_rdata,
  output logic [1:0]              s_axi_rresp,
  output logic                    s_axi_rvalid,
  input  wire logic               s_axi_rready,
  // receiver side
  input  wire logic [3:0]         decoderStrength,
  input  wire logic [7:0]         halfBitFirst,
  input  wire logic [7:0]         halfBitSecond,
  input  wire logic               halfBitValid,
  input  wire logic [7:0]         iStrength,
  input  wire logic [7:0]         qStrength,
  input  wire logic               commActive,
  input  wire logic               secureSerialMode,
  input  wire logic               receiving,
  input  wire logic               burstPhase,
  // timer side
  input  wire logic               timerEnable,
  input  wire logic [PRESC_W-1:0] timerPrescaleValue,
  output logic                    timerTick,
  // configuration and decisions to the analog part
  output logic [3:0]              minAcceptLevel,
  output logic [2:0]              collisionLevel,
  output logic                    decoderAccept,
  output logic                    bitCollision,
  output logic                    useIChannel,
  output logic                    useQChannel,
  output logic                    combineIQ,
  output logic [1:0]              secureIfConfig,
  output logic [1:0]              pllTimeConstant,
  output logic                    pllFreeze
);

  // ==========================================================
  // helpers

  // larger of two amplitudes
  function automatic logic [7:0] maxOf(input logic [7:0] a, input logic [7:0] b);
    maxOf = (a >= b) ? a : b;
  endfunction

  // smaller of two amplitudes
  function automatic logic [7:0] minOf(input logic [7:0] a, input logic [7:0] b);
    minOf = (a >= b) ? b : a;
  endfunction

  // true when the address matches a register word
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] regAddr);
    hit = (a == regAddr);
  endfunction

  // ==========================================================
  // register storage
  logic [7:0]        thresholdQ;
  logic [7:0]        demodQ;

  // bus handshake state
  logic              awHeldQ;
  logic              wHeldQ;
  logic [ADDR_W-1:0] awAddrQ;
  logic [7:0]        wDataQ;
  logic              wStrbQ;

  // channel hold state
  chanState_t        chanStateQ;
  logic              heldQChanQ;

  // field views
  logic [1:0]        chanField;
  logic              fixedField;
  logic              evenField;
  logic [1:0]        tauRcvField;
  logic [1:0]        tauSyncField;
  logic              fixedEff;
  logic              qStronger;
  logic              writeGo;
  logic [15:0]       weakScaled;
  logic [15:0]       strongScaled;

  assign chanField    = demodQ[CHUSE_HI:CHUSE_LO];
  assign fixedField   = demodQ[FIXCH_BIT];
  assign evenField    = demodQ[EVEN_BIT];
  assign tauRcvField  = demodQ[RECEIVE_TIME_CONSTANT_HI:RECEIVE_TIME_CONSTANT_LO];
  assign tauSyncField = demodQ[BURST_TIME_CONSTANT_HI:BURST_TIME_CONSTANT_LO];

  // secure serial mode behaves as if the fixed-channel bit were set
  assign fixedEff  = fixedField | secureSerialMode;
  assign qStronger = qStrength > iStrength;
  assign writeGo   = awHeldQ & wHeldQ & ~s_axi_bvalid;

  // collision ratio terms
  assign weakScaled   = 16'(minOf(halfBitFirst, halfBitSecond)) << COLL_SHIFT;
  assign strongScaled = 16'(maxOf(halfBitFirst, halfBitSecond)) * 16'(collisionLevel);

  // ==========================================================
  // write address channel
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      awHeldQ       <= 1'b0;
      awAddrQ       <= '0;
      s_axi_awready <= 1'b1;
    end else if (s_axi_awvalid && s_axi_awready) begin
      awHeldQ       <= 1'b1;
      awAddrQ       <= s_axi_awaddr;
      s_axi_awready <= 1'b0;
    end else if (s_axi_bvalid && s_axi_bready) begin
      awHeldQ       <= 1'b0;
      s_axi_awready <= 1'b1;
    end
  end

  // write data channel, only byte lane 0 carries register data
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      wHeldQ       <= 1'b0;
      wDataQ       <= '0;
      wStrbQ       <= 1'b0;
      s_axi_wready <= 1'b1;
    end else if (s_axi_wvalid && s_axi_wready) begin
      wHeldQ       <= 1'b1;
      wDataQ       <= s_axi_wdata[7:0];
      wStrbQ       <= s_axi_wstrb[0];
      s_axi_wready <= 1'b0;
    end else if (s_axi_bvalid && s_axi_bready) begin
      wHeldQ       <= 1'b0;
      s_axi_wready <= 1'b1;
    end
  end

  // write response once both address and data are held
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (writeGo) begin
      s_axi_bvalid <= 1'b1;
      if (hit(awAddrQ, THR_ADDR) || hit(awAddrQ, DEMOD_ADDR) || hit(awAddrQ, STAT_ADDR)) begin
        s_axi_bresp <= RESP_OKAY;
      end else begin
        s_axi_bresp <= RESP_SLVERR;
      end
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ==========================================================
  // configuration registers
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      thresholdQ <= THR_RST;
      demodQ     <= DEMOD_RST;
    end else if (writeGo && wStrbQ) begin
      if (hit(awAddrQ, THR_ADDR)) begin
        thresholdQ <= wDataQ & THR_WMASK;
      end
      if (hit(awAddrQ, DEMOD_ADDR)) begin
        demodQ <= wDataQ;
      end
    end
  end

  // ==========================================================
  // read channel, unused bits read zero
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rresp   <= RESP_OKAY;
      if (hit(s_axi_araddr, THR_ADDR)) begin
        s_axi_rdata <= {24'h000000, thresholdQ & THR_WMASK};
      end else if (hit(s_axi_araddr, DEMOD_ADDR)) begin
        s_axi_rdata <= {24'h000000, demodQ};
      end else if (hit(s_axi_araddr, STAT_ADDR)) begin
        s_axi_rdata <= {24'h000000, pllFreeze, bitCollision, decoderAccept,
                        combineIQ, useQChannel, useIChannel, heldQChanQ,
                        chanStateQ == CH_HELD};
      end else begin
        s_axi_rdata <= '0;
        s_axi_rresp <= RESP_SLVERR;
      end
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // ==========================================================
  // threshold fields to the decoder
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      minAcceptLevel <= THR_RST[MIN_LVL_HI:MIN_LVL_LO];
      collisionLevel <= THR_RST[COLL_HI:COLL_LO];
    end else begin
      minAcceptLevel <= thresholdQ[MIN_LVL_HI:MIN_LVL_LO];
      collisionLevel <= thresholdQ[COLL_HI:COLL_LO];
    end
  end

  // acceptance gate and collision detection
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      decoderAccept <= 1'b0;
      bitCollision  <= 1'b0;
    end else begin
      decoderAccept <= decoderStrength >= minAcceptLevel;
      bitCollision  <= halfBitValid && (decoderStrength >= minAcceptLevel)
                       && (weakScaled >= strongScaled);
    end
  end

  // ==========================================================
  // channel choice hold for the frozen selection mode
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      chanStateQ <= CH_FOLLOW;
      heldQChanQ <= 1'b0;
    end else begin
      case (chanStateQ)
        CH_FOLLOW: begin
          if (commActive && !fixedEff && chanField == CH_FREEZE) begin
            chanStateQ <= CH_HELD;
            heldQChanQ <= qStronger;
          end
        end
        CH_HELD: begin
          if (!commActive || fixedEff || chanField != CH_FREEZE) begin
            chanStateQ <= CH_FOLLOW;
          end
        end
        default: begin
          chanStateQ <= CH_FOLLOW;
        end
      endcase
    end
  end

  // channel steering outputs
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      useIChannel    <= 1'b1;
      useQChannel    <= 1'b0;
      combineIQ      <= 1'b0;
      secureIfConfig <= 2'h0;
    end else begin
      secureIfConfig <= secureSerialMode ? chanField : 2'h0;
      if (fixedEff) begin
        useIChannel <= ~chanField[0];
        useQChannel <= chanField[0];
        combineIQ   <= 1'b0;
      end else begin
        // field honoured only with the fixed bit clear
        case (chanField)
          CH_STRONGER: begin
            useIChannel <= ~qStronger;
            useQChannel <= qStronger;
            combineIQ   <= 1'b0;
          end
          CH_FREEZE: begin
            if (chanStateQ == CH_HELD) begin
              useIChannel <= ~heldQChanQ;
              useQChannel <= heldQChanQ;
            end else begin
              useIChannel <= ~qStronger;
              useQChannel <= qStronger;
            end
            combineIQ <= 1'b0;
          end
          CH_COMBINE: begin
            useIChannel <= 1'b1;
            useQChannel <= 1'b1;
            combineIQ   <= 1'b1;
          end
          default: begin
            // reserved code keeps the stronger channel
            useIChannel <= ~qStronger;
            useQChannel <= qStronger;
            combineIQ   <= 1'b0;
          end
        endcase
      end
    end
  end

  // ==========================================================
  // pll time constant by phase
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      pllTimeConstant <= DEMOD_RST[BURST_TIME_CONSTANT_HI:BURST_TIME_CONSTANT_LO];
      pllFreeze       <= 1'b0;
    end else if (receiving) begin
      pllTimeConstant <= tauRcvField;
      pllFreeze       <= tauRcvField == TAU_FROZEN;
    end else begin
      pllTimeConstant <= tauSyncField;
      pllFreeze       <= 1'b0;
    end
  end

  // ==========================================================
  // timer prescaler, sys_clk stands in for the carrier clock
  timer_tick_gen prescaler (
    .sys_clk       (sys_clk),
    .rstn          (rstn),
    .enable        (timerEnable),
    .evenPrescale  (evenField),
    .prescaleValue (timerPrescaleValue),
    .tick          (timerTick)
  );

endmodule

// *** rtl/rx_cfg_pkg.sv ***
package rx_cfg_pkg;

  // ==========================================================
  // bus geometry
  localparam int          ADDR_W = 8;
  localparam int          DATA_W = 32;

  // register indices and byte addresses (index * 4)
  localparam logic [7:0]  THR_IDX    = 8'h18;
  localparam logic [7:0]  DEMOD_IDX  = 8'h19;
  localparam logic [7:0]  STAT_IDX   = 8'h20;
  localparam logic [7:0]  THR_ADDR   = 8'(THR_IDX * 4);
  localparam logic [7:0]  DEMOD_ADDR = 8'(DEMOD_IDX * 4);
  localparam logic [7:0]  STAT_ADDR  = 8'(STAT_IDX * 4);

  // reset values
  localparam logic [7:0]  THR_RST   = 8'h84;
  localparam logic [7:0]  DEMOD_RST = 8'h4D;

  // threshold register fields
  localparam int          MIN_LVL_HI  = 7;
  localparam int          MIN_LVL_LO  = 4;
  localparam int          THR_RSV_BIT = 3;
  localparam int          COLL_HI     = 2;
  localparam int          COLL_LO     = 0;
  localparam logic [7:0]  THR_WMASK   = 8'hF7;

  // demodulator register fields
  localparam int          CHUSE_HI   = 7;
  localparam int          CHUSE_LO   = 6;
  localparam int          FIXCH_BIT  = 5;
  localparam int          EVEN_BIT   = 4;
  localparam int          RECEIVE_TIME_CONSTANT_HI  = 3;
  localparam int          RECEIVE_TIME_CONSTANT_LO  = 2;
  localparam int          BURST_TIME_CONSTANT_HI = 1;
  localparam int          BURST_TIME_CONSTANT_LO = 0;

  // channel-use and pll time-constant encodings
  localparam logic [1:0]  CH_STRONGER = 2'h0;
  localparam logic [1:0]  CH_FREEZE   = 2'h1;
  localparam logic [1:0]  CH_COMBINE  = 2'h2;
  localparam logic [1:0]  TAU_FROZEN  = 2'h0;

  // collision ratio scale: weaker*8 compared with stronger*level
  localparam int          COLL_SHIFT = 3;
  localparam int          PRESC_W    = 12;

  // axi responses
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  typedef enum logic {CH_FOLLOW, CH_HELD} chanState_t;

endpackage

// *** rtl/timer_tick_gen.sv ***
`timescale 1ns/10ps
module timer_tick_gen
  import rx_cfg_pkg::*;
(
  input  wire logic               sys_clk,
  input  wire logic               rstn,
  input  wire logic               enable,
  input  wire logic               evenPrescale,
  input  wire logic [PRESC_W-1:0] prescaleValue,
  output logic                    tick
);

  // ==========================================================
  // divisor arithmetic
  // divisor is 2*P+1 when odd form, 2*P+2 when even form
  function automatic logic [PRESC_W+1:0] lastCount(
    input logic               even,
    input logic [PRESC_W-1:0] p
  );
    logic [PRESC_W+1:0] div;
    div = {1'b0, p, 1'b0} + (even ? (PRESC_W+2)'(2) : (PRESC_W+2)'(1));
    lastCount = div - (PRESC_W+2)'(1);
  endfunction

  logic [PRESC_W+1:0] cntQ;

  // ==========================================================
  // counter wraps at the terminal count, one tick per period
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      cntQ <= '0;
      tick <= 1'b0;
    end else if (!enable) begin
      cntQ <= '0;
      tick <= 1'b0;
    end else if (cntQ >= lastCount(evenPrescale, prescaleValue)) begin
      cntQ <= '0;
      tick <= 1'b1;
    end else begin
      cntQ <= cntQ + (PRESC_W+2)'(1);
      tick <= 1'b0;
    end
  end

endmodule

// *** test/rx_cfg_props.sv ***
`timescale 1ns/10ps
// ==========================================
// bus handshake and decision checks
module rx_cfg_props
  import rx_cfg_pkg::*;
(
  input wire logic       sys_clk,
  input wire logic       rstn,
  input wire logic       s_axi_awvalid,
  input wire logic       s_axi_awready,
  input wire logic       s_axi_wvalid,
  input wire logic       s_axi_wready,
  input wire logic       s_axi_bvalid,
  input wire logic       s_axi_bready,
  input wire logic       s_axi_arvalid,
  input wire logic       s_axi_arready,
  input wire logic       s_axi_rvalid,
  input wire logic       s_axi_rready,
  input wire logic [3:0] decoderStrength,
  input wire logic [7:0] halfBitFirst,
  input wire logic [7:0] halfBitSecond,
  input wire logic       halfBitValid,
  input wire logic       secureSerialMode,
  input wire logic       receiving,
  input wire logic       timerEnable,
  input wire logic       timerTick,
  input wire logic [3:0] minAcceptLevel,
  input wire logic [2:0] collisionLevel,
  input wire logic       bitCollision,
  input wire logic       decoderAccept,
  input wire logic       useIChannel,
  input wire logic       useQChannel,
  input wire logic       combineIQ,
  input wire logic [1:0] pllTimeConstant,
  input wire logic       pllFreeze
);
  default clocking dc @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  // weaker half-bit times eight against stronger times level
  function automatic logic collides(logic [7:0] a, logic [7:0] b, logic [2:0] l);
    return (a < b ? a : b) * 11'd8 >= (a < b ? b : a) * 11'(l);
  endfunction

  // handshake steps
  sequence wrTaken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence rdTaken;
    s_axi_arvalid && s_axi_arready;
  endsequence

  // ==========================================
  // assertions
  chk_write_answer: assert property (wrTaken |=> !s_axi_awready && !s_axi_wready ##1 s_axi_bvalid)
    else $error("write answer missing");
  chk_write_release: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && s_axi_awready)
    else $error("write response not released");
  chk_read_answer: assert property (rdTaken |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer missing");
  chk_read_release: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready)
    else $error("read data not released");
  chk_accept_level: assert property (1 |=> decoderAccept == ($past(decoderStrength) >= $past(minAcceptLevel)))
    else $error("accept differs from level");
  chk_collision_ratio: assert property (1 |=> bitCollision == ($past(halfBitValid)
      && $past(decoderStrength) >= $past(minAcceptLevel)
      && collides($past(halfBitFirst), $past(halfBitSecond), $past(collisionLevel))))
    else $error("collision flag wrong");
  chk_pll_freeze: assert property (pllFreeze |-> pllTimeConstant == TAU_FROZEN && $past(receiving))
    else $error("freeze outside reception");
  chk_secure_fixed: assert property (secureSerialMode |=> !combineIQ && (useIChannel != useQChannel))
    else $error("serial mode not fixed");
  chk_tick_idle: assert property (!timerEnable |=> !timerTick)
    else $error("tick while disabled");
endmodule

// *** test/axi_host_model.sv ***
`timescale 1ns/10ps
// ==========================================
// host controller on the register bus
module axi_host_model
  import rx_cfg_pkg::*;
(
  input  wire logic              sys_clk,
  output logic [ADDR_W-1:0]      s_axi_awaddr,
  output logic                   s_axi_awvalid,
  input  wire logic              s_axi_awready,
  output logic [DATA_W-1:0]      s_axi_wdata,
  output logic [3:0]             s_axi_wstrb,
  output logic                   s_axi_wvalid,
  input  wire logic              s_axi_wready,
  input  wire logic [1:0]        s_axi_bresp,
  input  wire logic              s_axi_bvalid,
  output logic                   s_axi_bready,
  output logic [ADDR_W-1:0]      s_axi_araddr,
  output logic                   s_axi_arvalid,
  input  wire logic              s_axi_arready,
  input  wire logic [DATA_W-1:0] s_axi_rdata,
  input  wire logic [1:0]        s_axi_rresp,
  input  wire logic              s_axi_rvalid,
  output logic                   s_axi_rready
);
  // idle bus at time zero
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = 52'h0;
  end

  // one write; released lines carry the inverse of the old value
  task wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d, output logic [1:0] r);
    logic awDone, wDone;
    @(posedge sys_clk);
    {s_axi_awaddr, s_axi_wdata, s_axi_wstrb} <= {a, d, 4'hF};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    {awDone, wDone} = 2'h0;
    while (!(awDone && wDone)) begin
      @(posedge sys_clk);
      if (!awDone && s_axi_awready) begin
        awDone = 1'b1;
        {s_axi_awvalid, s_axi_awaddr} <= {1'b0, ~a};
      end
      if (!wDone && s_axi_wready) begin
        wDone = 1'b1;
        {s_axi_wvalid, s_axi_wdata} <= {1'b0, ~d};
      end
    end
    while (!s_axi_bvalid) @(posedge sys_clk);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  // one read
  task rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d, output logic [1:0] r);
    @(posedge sys_clk);
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'h3};
    do @(posedge sys_clk); while (!s_axi_arready);
    {s_axi_araddr, s_axi_arvalid} <= {~a, 1'b0};
    do @(posedge sys_clk); while (!s_axi_rvalid);
    {d, r} = {s_axi_rdata, s_axi_rresp};
    s_axi_rready <= 1'b0;
  endtask
endmodule

// *** test/testbench.sv ***
`timescale 1ns/10ps
// ==========================================
// checker attachment
bind rx_threshold_demod_config rx_cfg_props props (.sys_clk, .rstn, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
  .s_axi_rready, .decoderStrength, .halfBitFirst, .halfBitSecond, .halfBitValid, .secureSerialMode, .receiving,
  .timerEnable, .timerTick, .minAcceptLevel, .collisionLevel, .bitCollision, .decoderAccept, .useIChannel,
  .useQChannel, .combineIQ, .pllTimeConstant, .pllFreeze);

module testbench
  import rx_cfg_pkg::*;
;
  logic [7:0]         s_axi_awaddr, s_axi_araddr, halfBitFirst, halfBitSecond, iStrength, qStrength;
  logic [31:0]        s_axi_wdata, s_axi_rdata, rdat;
  logic [3:0]         s_axi_wstrb, decoderStrength, minAcceptLevel;
  logic [1:0]         s_axi_bresp, s_axi_rresp, secureIfConfig, pllTimeConstant, resp;
  logic [2:0]         collisionLevel;
  logic [PRESC_W-1:0] timerPrescaleValue;
  logic               sys_clk, rstn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic               s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, halfBitValid;
  logic               commActive, secureSerialMode, receiving, burstPhase, timerEnable, timerTick;
  logic               decoderAccept, bitCollision, useIChannel, useQChannel, combineIQ, pllFreeze;
  int                 fails = 0, n_checks = 0, cyc = 0, gap;

  // ==========================================
  // design and host
  rx_threshold_demod_config dut (.sys_clk, .rstn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .decoderStrength,
    .halfBitFirst, .halfBitSecond, .halfBitValid, .iStrength, .qStrength, .commActive, .secureSerialMode,
    .receiving, .burstPhase, .timerEnable, .timerPrescaleValue, .timerTick, .minAcceptLevel, .collisionLevel,
    .decoderAccept, .bitCollision, .useIChannel, .useQChannel, .combineIQ, .secureIfConfig, .pllTimeConstant,
    .pllFreeze);
  axi_host_model host (.sys_clk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

  // 100 ns clock
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  // hang guard
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      fails++;
      give_verdict();
    end
  end

  // ==========================================
  // helpers
  task give_verdict();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task step(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    host.wr(a, {24'h0, d}, resp);
    chk(resp, RESP_OKAY);
  endtask
  task rdChk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    host.rd(a, rdat, resp);
    chk(rdat, e);
    chk(resp, er);
  endtask
  task chan(input logic [7:0] d, input logic [2:0] e);
    wr(DEMOD_ADDR, d);
    step(3);
    chk({useIChannel, useQChannel, combineIQ}, e);
  endtask
  task pll(input logic [7:0] d, input logic r, input logic [2:0] e);
    receiving <= r;
    wr(DEMOD_ADDR, d);
    step(3);
    chk({pllTimeConstant, pllFreeze}, e);
  endtask
  task tgap(input logic [7:0] d, input int e);
    wr(DEMOD_ADDR, d);
    repeat (2) do step(1); while (!timerTick);
    gap = 0;
    do begin step(1); gap++; end while (!timerTick);
    chk(gap, e);
  endtask

  // ==========================================
  // main sequence
  initial begin
    {rstn, halfBitValid, commActive, secureSerialMode, receiving, burstPhase, timerEnable} = 7'h0;
    {decoderStrength, halfBitFirst, halfBitSecond, iStrength, qStrength, timerPrescaleValue} = 48'h0;
    step(16);
    rstn <= 1'b1;
    step(2);
    chk({minAcceptLevel, collisionLevel}, {4'h8, 3'h4});
    rdChk(THR_ADDR, 32'h84, RESP_OKAY);
    rdChk(DEMOD_ADDR, 32'h4D, RESP_OKAY);
    chk({pllTimeConstant, pllFreeze}, 3'h2);
    wr(THR_ADDR, 8'hFF);
    rdChk(THR_ADDR, 32'hF7, RESP_OKAY);
    chk({minAcceptLevel, collisionLevel}, 7'h7F);
    host.wr(8'h04, 32'h5A, resp);
    chk(resp, RESP_SLVERR);
    rdChk(8'h04, 32'h0, RESP_SLVERR);
    wr(THR_ADDR, 8'h54);
    {halfBitValid, halfBitFirst, halfBitSecond, decoderStrength} <= {1'b1, 8'd100, 8'd50, 4'h4};
    step(3);
    chk({decoderAccept, bitCollision}, 2'h0);
    decoderStrength <= 4'h5;
    step(3);
    chk({decoderAccept, bitCollision}, 2'h3);
    halfBitSecond <= 8'd49;
    step(3);
    chk(bitCollision, 1'b0);
    {iStrength, qStrength} <= {8'd80, 8'd20};
    chan(8'h00, 3'b100);
    chan(8'h20, 3'b100);
    chan(8'h60, 3'b010);
    chan(8'hA0, 3'b100);
    chan(8'h80, 3'b111);
    chan(8'hC0, 3'b100);
    qStrength <= 8'd100;
    chan(8'h00, 3'b010);
    qStrength <= 8'd20;
    chan(8'h40, 3'b100);
    commActive <= 1'b1;
    step(3);
    qStrength <= 8'd100;
    step(3);
    chk({useIChannel, useQChannel}, 2'b10);
    commActive <= 1'b0;
    step(3);
    chk({useIChannel, useQChannel}, 2'b01);
    {qStrength, secureSerialMode} <= {8'd20, 1'b1};
    chan(8'h40, 3'b010);
    chk(secureIfConfig, 2'h1);
    secureSerialMode <= 1'b0;
    pll(8'h42, 1'b1, 3'b001);
    pll(8'h4A, 1'b1, 3'b100);
    pll(8'h47, 1'b0, 3'b110);
    rdChk(STAT_ADDR, 32'h24, RESP_OKAY);
    {timerEnable, timerPrescaleValue} <= {1'b1, 12'h003};
    tgap(8'h00, 7);
    tgap(8'h10, 8);
    timerEnable <= 1'b0;
    step(3);
    give_verdict();
  end
endmodule
